// ===== design/ifmc_consts.svh
`ifndef IFMC_CONSTS_SVH
`define IFMC_CONSTS_SVH

// register byte addresses
`define IFMC_OFS_REQ 16'hFFE0
`define IFMC_OFS_MASK 16'hFFE4
`define IFMC_OFS_EDGE 16'hFFEC
`define IFMC_OFS_KEY 16'hFFF0
`define IFMC_OFS_PSW 16'hFFF4

// reset values
`define IFMC_RST_REQ 8'h00
`define IFMC_RST_MASK 8'hFF
`define IFMC_RST_EDGE 8'h00
`define IFMC_RST_KEY 8'h00
`define IFMC_RST_PSW 8'h02

// field positions
`define IFMC_BIT_WDT 0
`define IFMC_BIT_EXT 1
`define IFMC_BIT_KEY 6
`define IFMC_EDGE_LO 2
`define IFMC_EDGE_HI 3
`define IFMC_KEY_EN 0
`define IFMC_PSW_IE 7

// edge select codes
`define IFMC_EDGE_FALL 2'h0
`define IFMC_EDGE_RISE 2'h1
`define IFMC_EDGE_BAD 2'h2
`define IFMC_EDGE_BOTH 2'h3

// watchdog run modes
`define IFMC_WDT_INTERVAL 2'h0

`endif

// ===== design/ifmc_pkg.sv
package ifmc_pkg;

    // apb request group from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } ifmc_apb_req_t;

    // apb answer group to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ifmc_apb_rsp_t;

    // core acknowledge of a vectored request
    typedef struct packed {
        logic valid;
        logic [2:0] index;
    } ifmc_ack_t;

    // request presented to the core
    typedef struct packed {
        logic valid;
        logic [2:0] index;
    } ifmc_irq_t;

    // status word pushed at acknowledge
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ifmc_push_t;

    // apb phase tracker
    typedef enum logic [1:0] {
        IFMC_IDLE = 2'b01,
        IFMC_DONE = 2'b10
    } ifmc_phase_t;

endpackage

// ===== design/ifmc_ctrl.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "ifmc_consts.svh"
// Functional notes
// RL1: source event or software write sets flag
// RL2: acknowledge or software write clears flag
// RL3: reset clears request flags
// RL4: mask zero allows, one blocks servicing
// RL5: reset sets all mask flags
// RL6: edge field picks falling, rising, both
// RL7: reset clears edge select, falling edge
// RL8: software writes zero to unused edge bits
// RL9: software masks pin around edge changes
// RL10: acknowledge pushes status word, clears enable
// RL11: reset loads status word 02H
// RL12: status word writable, enable/disable strobes
// RL13: reset clears key return control
// RL14: enabled key falling edge raises request
// RL15: software writes zero to key bits 1-7
// RL16: key request only from all-high keys
// RL17: key detection independent of pin direction
// RL18: software masks key source around changes
// RL19: watchdog flag usable only in interval mode
// RL20: watchdog mask read undefined in watchdog modes
// RL21: software parks unused serial source bits
// RL22: software masks pin before port output use
// RL23: service needs flag, clear mask, enable
// RL24: lowest numbered pending source wins
// RL25: requests held during flag/mask register access
// RL26: prohibited edge code raises nothing

// request and mask bit map, one bit per source, index is also priority:
//   0 watchdog interval overflow
//   1 external pin edge
//   2 serial receive end
//   3 watch timer
//   4 timer a match
//   5 timer b match
//   6 key return
//   7 watch interval
// bits 1 and 6 come from the pin detectors here, the rest from srcEvent
// status word: bit 7 is the global enable, the other bits are plain storage
module ifmc_ctrl
    import ifmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    // register bus
    input wire ifmc_apb_req_t apbReq,
    output ifmc_apb_rsp_t apbRsp,
    // peripheral sources, same clock
    input wire logic [7:0] srcEvent,
    input wire logic [1:0] wdtMode,
    // asynchronous pins
    input wire logic sharedExtIrqPin,
    input wire logic [3:0] keyInputPins,
    // core side
    input wire logic enableIrqInstr,
    input wire logic disableIrqInstr,
    input wire ifmc_ack_t coreAck,
    output ifmc_irq_t coreIrq,
    output ifmc_push_t pswPush,
    output logic globalIrqEnable
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // priority pick, lowest index first
    function automatic logic [2:0] pickFirst(input logic [7:0] vec);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (vec[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // address match on the low 16 bits
    function automatic logic hitAddr(input logic [15:0] a, input logic [15:0] ofs);
        return a == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, two stages each, then a history stage

    logic [4:0] pinMeta_reg;
    logic [4:0] pinSync_reg;
    logic [4:0] pinHist_reg;
    logic [4:0] pinMeta_next;
    logic [4:0] pinSync_next;
    logic [4:0] pinHist_next;

    // bit 4 is the external pin, 3:0 the key port
    always_comb begin
        pinMeta_next = {sharedExtIrqPin, keyInputPins};
        pinSync_next = pinMeta_reg;
        pinHist_next = pinSync_reg;
    end

    // no reset here: the chain tracks the pins through reset, so a pin that
    // sits low at release shows no edge; a forced idle level would fake one
    // limitation: a pin change inside a reset shorter than three edges can show
    always_ff @(posedge clk_sys) begin
        pinMeta_reg <= pinMeta_next;
        pinSync_reg <= pinSync_next;
        pinHist_reg <= pinHist_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers and apb slave

    logic [7:0] reqFlag_reg;
    logic [7:0] reqFlag_next;
    logic [7:0] maskFlag_reg;
    logic [7:0] maskFlag_next;
    logic [7:0] edgeSel_reg;
    logic [7:0] edgeSel_next;
    logic [7:0] keyCtrl_reg;
    logic [7:0] keyCtrl_next;
    logic [7:0] psw_reg;
    logic [7:0] psw_next;
    ifmc_phase_t phase_reg;
    ifmc_phase_t phase_next;
    ifmc_apb_rsp_t rsp_reg;
    ifmc_apb_rsp_t rsp_next;
    ifmc_irq_t irq_reg;
    ifmc_irq_t irq_next;
    ifmc_push_t push_reg;
    ifmc_push_t push_next;

    logic extRise;
    logic extFall;
    logic extHit;
    logic keyHit;
    logic [1:0] edgeCode;
    logic inInterval;
    logic [7:0] hwSet;
    logic [7:0] ackClr;
    logic wrCommit;
    logic wrReq;
    logic wrMask;
    logic wrEdge;
    logic wrKey;
    logic wrPsw;
    logic mapped;
    logic holdOff;
    logic [7:0] ready;
    logic [7:0] rdByte;

    // edge and key detection on synchronised levels
    // the prohibited edge code decodes to silence rather than a guess, since
    // software may pass through it while changing the two field bits
    always_comb begin
        edgeCode = {edgeSel_reg[`IFMC_EDGE_HI], edgeSel_reg[`IFMC_EDGE_LO]};
        extRise = pinSync_reg[4] & ~pinHist_reg[4];
        extFall = ~pinSync_reg[4] & pinHist_reg[4];
        case (edgeCode) // RL6
            `IFMC_EDGE_FALL: extHit = extFall;
            `IFMC_EDGE_RISE: extHit = extRise;
            `IFMC_EDGE_BOTH: extHit = extRise | extFall;
            default: extHit = 1'b0; // RL26
        endcase
        // pins are sensed as levels only, so port direction does not matter
        keyHit = keyCtrl_reg[`IFMC_KEY_EN] & (&pinHist_reg[3:0])
            & ~(&pinSync_reg[3:0]); // RL14 RL16 RL17
    end

    // hardware set sources and acknowledge clear
    // srcEvent bits 1 and 6 are overridden by the local pin detectors
    always_comb begin
        inInterval = wdtMode == `IFMC_WDT_INTERVAL;
        hwSet = srcEvent; // RL1
        hwSet[`IFMC_BIT_EXT] = extHit;
        hwSet[`IFMC_BIT_KEY] = keyHit;
        // watchdog overflow only counts as maskable in interval mode
        hwSet[`IFMC_BIT_WDT] = srcEvent[`IFMC_BIT_WDT] & inInterval; // RL19
        ackClr = 8'h00;
        if (coreAck.valid) begin
            ackClr[coreAck.index] = 1'b1; // RL2
        end
    end

    // apb decode; writes take effect at the edge that sees pready
    // a write is applied once, at the edge that closes the access phase;
    // a write to an unmapped address changes nothing
    always_comb begin
        wrCommit = apbReq.psel & apbReq.penable & apbReq.pwrite & rsp_reg.pready;
        wrReq = wrCommit & hitAddr(apbReq.paddr, `IFMC_OFS_REQ);
        wrMask = wrCommit & hitAddr(apbReq.paddr, `IFMC_OFS_MASK);
        wrEdge = wrCommit & hitAddr(apbReq.paddr, `IFMC_OFS_EDGE);
        wrKey = wrCommit & hitAddr(apbReq.paddr, `IFMC_OFS_KEY);
        wrPsw = wrCommit & hitAddr(apbReq.paddr, `IFMC_OFS_PSW);
        mapped = hitAddr(apbReq.paddr, `IFMC_OFS_REQ) | hitAddr(apbReq.paddr, `IFMC_OFS_MASK)
            | hitAddr(apbReq.paddr, `IFMC_OFS_EDGE) | hitAddr(apbReq.paddr, `IFMC_OFS_KEY)
            | hitAddr(apbReq.paddr, `IFMC_OFS_PSW);
        // any transfer to flag or mask registers freezes new requests
        holdOff = apbReq.psel & (hitAddr(apbReq.paddr, `IFMC_OFS_REQ)
            | hitAddr(apbReq.paddr, `IFMC_OFS_MASK)); // RL25
    end

    // one update cell per flag bit: software or held value, then acknowledge
    // clear, then hardware set, so a set in the clear cycle wins
    for (genvar b = 0; b < 8; b++) begin : g_flag
        logic swBit;
        // watchdog bit ignores software while the timer guards the core
        assign swBit = (b == `IFMC_BIT_WDT && !inInterval) ? reqFlag_reg[b]
            : apbReq.pwdata[b]; // RL19
        assign reqFlag_next[b] = ((wrReq ? swBit : reqFlag_reg[b]) & ~ackClr[b])
            | hwSet[b]; // RL1 RL2
    end

    // configuration registers; unused bits are stored as written
    always_comb begin
        maskFlag_next = wrMask ? apbReq.pwdata[7:0] : maskFlag_reg;
        // software keeps the spare edge and key bits at zero
        edgeSel_next = wrEdge ? apbReq.pwdata[7:0] : edgeSel_reg;
        keyCtrl_next = wrKey ? apbReq.pwdata[7:0] : keyCtrl_reg;
    end

    // status word; disable beats enable, acknowledge beats both
    always_comb begin
        psw_next = wrPsw ? apbReq.pwdata[7:0] : psw_reg; // RL12
        if (enableIrqInstr) begin
            psw_next[`IFMC_PSW_IE] = 1'b1; // RL12
        end
        if (disableIrqInstr) begin
            psw_next[`IFMC_PSW_IE] = 1'b0; // RL12
        end
        if (coreAck.valid) begin
            psw_next[`IFMC_PSW_IE] = 1'b0; // RL10
        end
    end

    // read mux and one-cycle answer in the first access cycle
    always_comb begin
        case (1'b1)
            hitAddr(apbReq.paddr, `IFMC_OFS_REQ): rdByte = reqFlag_reg;
            // watchdog mask reads back as stored; value is meaningless there
            hitAddr(apbReq.paddr, `IFMC_OFS_MASK): rdByte = maskFlag_reg; // RL20
            hitAddr(apbReq.paddr, `IFMC_OFS_EDGE): rdByte = edgeSel_reg;
            hitAddr(apbReq.paddr, `IFMC_OFS_KEY): rdByte = keyCtrl_reg;
            hitAddr(apbReq.paddr, `IFMC_OFS_PSW): rdByte = psw_reg;
            default: rdByte = 8'h00;
        endcase
    end

    // answer is registered, so pready comes in the first access cycle and
    // read data shows the registers as they stood in the setup cycle
    always_comb begin
        phase_next = phase_reg;
        rsp_next = '0;
        case (phase_reg)
            IFMC_IDLE: begin
                if (apbReq.psel & ~apbReq.penable) begin
                    phase_next = IFMC_DONE;
                    rsp_next.pready = 1'b1;
                    rsp_next.pslverr = ~mapped;
                    rsp_next.prdata = apbReq.pwrite ? 32'h0000_0000 : {24'h000000, rdByte};
                end
            end
            IFMC_DONE: begin
                phase_next = IFMC_IDLE;
            end
            default: begin
                phase_next = IFMC_IDLE;
            end
        endcase
    end

    // arbitration toward the core
    // the acknowledged source leaves the pick in its own cycle, and the request
    // drops after each acknowledge and stays down until the enable is set again
    always_comb begin
        ready = reqFlag_reg & ~maskFlag_reg & ~ackClr; // RL4 RL23
        irq_next.valid = (|ready) & psw_reg[`IFMC_PSW_IE] & ~coreAck.valid
            & ~holdOff; // RL23 RL25
        irq_next.index = pickFirst(ready); // RL24
        push_next.valid = coreAck.valid; // RL10
        push_next.data = psw_reg; // RL10
    end

    // request flags
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reqFlag_reg <= `IFMC_RST_REQ; // RL3
        end else begin
            reqFlag_reg <= reqFlag_next;
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            maskFlag_reg <= `IFMC_RST_MASK; // RL5
            edgeSel_reg <= `IFMC_RST_EDGE; // RL7
            keyCtrl_reg <= `IFMC_RST_KEY; // RL13
        end else begin
            maskFlag_reg <= maskFlag_next;
            edgeSel_reg <= edgeSel_next;
            keyCtrl_reg <= keyCtrl_next;
        end
    end

    // status word
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            psw_reg <= `IFMC_RST_PSW; // RL11
        end else begin
            psw_reg <= psw_next;
        end
    end

    // bus slave answer
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            phase_reg <= IFMC_IDLE;
            rsp_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            rsp_reg <= rsp_next;
        end
    end

    // core side request and push
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            irq_reg <= '0;
            push_reg <= '0;
        end else begin
            irq_reg <= irq_next;
            push_reg <= push_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops

    assign apbRsp = rsp_reg;
    assign coreIrq = irq_reg;
    assign pswPush = push_reg;
    assign globalIrqEnable = psw_reg[`IFMC_PSW_IE];

endmodule

// ===== test/ifmc_core_model.sv
`timescale 1ns/1ps
module ifmc_core_model
    import ifmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input ifmc_irq_t coreIrq,
    input wire logic ackEn,
    output ifmc_ack_t coreAck,
    output logic [2:0] lastIdx
);
    // registered answer: one ack per request, never while the previous one is in flight
    always @(posedge clk_sys) begin
        coreAck <= '0;
        if (!rstn) begin
            lastIdx <= 3'h0;
        end else if (ackEn && coreIrq.valid === 1'b1 && !coreAck.valid) begin
            coreAck <= '{1'b1, coreIrq.index};
            lastIdx <= coreIrq.index;
        end
    end
endmodule

// ===== test/ifmc_ctrl_properties.sv
`timescale 1ns/1ps
`include "ifmc_consts.svh"
module ifmc_ctrl_properties
    import ifmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input ifmc_apb_req_t apbReq,
    input ifmc_apb_rsp_t apbRsp,
    input wire logic [7:0] srcEvent,
    input wire logic [1:0] wdtMode,
    input wire logic sharedExtIrqPin,
    input wire logic [3:0] keyInputPins,
    input wire logic enableIrqInstr,
    input wire logic disableIrqInstr,
    input ifmc_ack_t coreAck,
    input ifmc_irq_t coreIrq,
    input ifmc_push_t pswPush,
    input wire logic globalIrqEnable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_push_pulse: assert property (coreAck.valid |=> pswPush.valid ##1 !pswPush.valid)
        else $error("acknowledge without a single push pulse");
    a_ack_clears_ie: assert property (coreAck.valid |=> !globalIrqEnable)
        else $error("enable still set after acknowledge");
    a_push_old_ie: assert property (pswPush.valid |-> pswPush.data[`IFMC_PSW_IE] == $past(globalIrqEnable))
        else $error("pushed status word lost the enable bit");
    a_irq_needs_ie: assert property (coreIrq.valid |-> $past(globalIrqEnable))
        else $error("request raised while disabled");
    a_hold_on_access: assert property (apbReq.psel && apbReq.penable &&
        (apbReq.paddr == `IFMC_OFS_REQ || apbReq.paddr == `IFMC_OFS_MASK) |-> !coreIrq.valid)
        else $error("request shown during flag register access");
    a_irq_gap_ack: assert property (coreAck.valid |=> !coreIrq.valid)
        else $error("acknowledged request still shown");
    a_di_clears_ie: assert property (disableIrqInstr |=> !globalIrqEnable)
        else $error("disable strobe left enable set");
    a_reset_state: assert property (disable iff (1'b0) !rstn |=> !globalIrqEnable && !coreIrq.valid)
        else $error("reset left enable or request set");
    // slave answers in the first access cycle, for exactly one cycle
    a_ready_single: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready ##1 !apbRsp.pready)
        else $error("ready not a single cycle after setup");
endmodule
bind ifmc_ctrl ifmc_ctrl_properties i_ifmc_ctrl_properties (.clk_sys(clk_sys), .rstn(rstn),
    .apbReq(apbReq), .apbRsp(apbRsp), .srcEvent(srcEvent), .wdtMode(wdtMode),
    .sharedExtIrqPin(sharedExtIrqPin), .keyInputPins(keyInputPins),
    .enableIrqInstr(enableIrqInstr), .disableIrqInstr(disableIrqInstr), .coreAck(coreAck),
    .coreIrq(coreIrq), .pswPush(pswPush), .globalIrqEnable(globalIrqEnable));

// ===== test/interrupt_flag_mask_control_tb_top.sv
`timescale 1ns/1ps
`include "ifmc_consts.svh"
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
module interrupt_flag_mask_control_tb_top
    import ifmc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    ifmc_apb_req_t apbReq = '0;
    ifmc_apb_rsp_t apbRsp;
    logic [7:0] srcEvent = 8'h00;
    logic extPin = 1'b1;
    logic [3:0] keyPins = 4'hF;
    logic [1:0] wdtMode = 2'h0;
    logic enIrq = 1'b0, diIrq = 1'b0, ackEn = 1'b0, ie, rowW, rowE, e;
    ifmc_ack_t coreAck;
    ifmc_irq_t coreIrq;
    ifmc_push_t pswPush;
    logic [2:0] lastIdx;
    logic [15:0] rowA;
    logic [7:0] rowD, rowX, q;
    int errCount = 0, samplesChecked = 0, i;
    // write, address, data, expected read byte, expected error
    localparam logic [33:0] ROWS [13] = '{
        {1'b0, `IFMC_OFS_REQ, 16'h0000, 1'b0}, {1'b0, `IFMC_OFS_MASK, 16'h00FF, 1'b0},
        {1'b0, `IFMC_OFS_EDGE, 16'h0000, 1'b0}, {1'b0, `IFMC_OFS_KEY, 16'h0000, 1'b0},
        {1'b0, `IFMC_OFS_PSW, 16'h0002, 1'b0}, {1'b0, 16'hFFE8, 16'h0000, 1'b1},
        {1'b1, `IFMC_OFS_MASK, 16'h5A00, 1'b0}, {1'b0, `IFMC_OFS_MASK, 16'h005A, 1'b0},
        {1'b1, `IFMC_OFS_REQ, 16'h2400, 1'b0}, {1'b0, `IFMC_OFS_REQ, 16'h0024, 1'b0},
        {1'b1, `IFMC_OFS_REQ, 16'h0000, 1'b0}, {1'b0, `IFMC_OFS_REQ, 16'h0000, 1'b0},
        {1'b1, 16'hFFE8, 16'h0000, 1'b1}};

    ifmc_ctrl i_ifmc_ctrl (.clk_sys(clk_sys), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp),
        .srcEvent(srcEvent), .wdtMode(wdtMode), .sharedExtIrqPin(extPin),
        .keyInputPins(keyPins), .enableIrqInstr(enIrq), .disableIrqInstr(diIrq),
        .coreAck(coreAck), .coreIrq(coreIrq), .pswPush(pswPush), .globalIrqEnable(ie));
    ifmc_core_model i_ifmc_core_model (.clk_sys(clk_sys), .rstn(rstn), .coreIrq(coreIrq),
        .ackEn(ackEn), .coreAck(coreAck), .lastIdx(lastIdx));

    always #2.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize(input int timedOut);
        errCount += timedOut;
        $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // request held until ready is seen high at an edge, then released
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys) apbReq <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge clk_sys) apbReq.penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (apbRsp.pready === 1'b1) break;
        end
        q = apbRsp.prdata[7:0];
        e = apbRsp.pslverr;
        apbReq <= '0;
        if (n == 20) summarize(1);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        `CHK(q, x)
    endtask
    task automatic pulse(input logic [7:0] ev, input logic en, input logic di);
        @(posedge clk_sys) {srcEvent, enIrq, diIrq} <= {ev, en, di};
        @(posedge clk_sys) {srcEvent, enIrq, diIrq} <= 10'h000;
    endtask
    // push pulse is sampled at the edge that ends its cycle
    task automatic waitPush;
        int n;
        for (n = 0; n < 30; n++) begin
            @(posedge clk_sys);
            if (pswPush.valid === 1'b1) break;
        end
        if (n == 30) summarize(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        for (i = 0; i < 13; i++) begin
            {rowW, rowA, rowD, rowX, rowE} = ROWS[i];
            apb(rowW, rowA, rowD);
            `CHK(q, rowX)
            `CHK(e, rowE)
        end
        // two pending sources, lowest index first, enable dropped by each ack
        apb(1'b1, `IFMC_OFS_MASK, 8'h00);
        apb(1'b1, `IFMC_OFS_PSW, 8'h82);
        pulse(8'h28, 1'b0, 1'b0);
        repeat (3) @(posedge clk_sys);
        `CHK(coreIrq.valid, 1'b1)
        `CHK(coreIrq.index, 3'h3)
        ackEn <= 1'b1;
        waitPush();
        `CHK(pswPush.data, 8'h82)
        `CHK(ie, 1'b0)
        `CHK(lastIdx, 3'h3)
        rd(`IFMC_OFS_REQ, 8'h20);
        `CHK(coreIrq.valid, 1'b0)
        pulse(8'h00, 1'b1, 1'b0);
        waitPush();
        `CHK(lastIdx, 3'h5)
        `CHK(pswPush.data, 8'h82)
        rd(`IFMC_OFS_REQ, 8'h00);
        // masked source stays pending; access holds it off; disable beats enable
        ackEn <= 1'b0;
        apb(1'b1, `IFMC_OFS_MASK, 8'h08);
        pulse(8'h08, 1'b1, 1'b0);
        repeat (6) @(posedge clk_sys);
        `CHK(coreIrq.valid, 1'b0)
        rd(`IFMC_OFS_REQ, 8'h08);
        apb(1'b1, `IFMC_OFS_MASK, 8'h00);
        repeat (3) @(posedge clk_sys);
        `CHK(coreIrq.valid, 1'b1)
        rd(`IFMC_OFS_REQ, 8'h08);
        `CHK(coreIrq.valid, 1'b0)
        pulse(8'h00, 1'b1, 1'b1);
        @(posedge clk_sys);
        `CHK(ie, 1'b0)
        apb(1'b1, `IFMC_OFS_MASK, 8'hFF);
        // every edge code against a fall and a rise of the pin
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `IFMC_OFS_EDGE, {4'h0, i[1:0], 2'b00});
            apb(1'b1, `IFMC_OFS_REQ, 8'h00);
            extPin <= 1'b0;
            repeat (6) @(posedge clk_sys);
            rd(`IFMC_OFS_REQ, {6'h00, (i == 0 || i == 3), 1'b0});
            apb(1'b1, `IFMC_OFS_REQ, 8'h00);
            extPin <= 1'b1;
            repeat (6) @(posedge clk_sys);
            rd(`IFMC_OFS_REQ, {6'h00, (i == 1 || i == 3), 1'b0});
        end
        // key return: off after reset, then only from an all-high port
        apb(1'b1, `IFMC_OFS_REQ, 8'h00);
        keyPins <= 4'hE;
        repeat (6) @(posedge clk_sys);
        rd(`IFMC_OFS_REQ, 8'h00);
        keyPins <= 4'hF;
        apb(1'b1, `IFMC_OFS_KEY, 8'h01);
        keyPins <= 4'hE;
        repeat (6) @(posedge clk_sys);
        rd(`IFMC_OFS_REQ, 8'h40);
        apb(1'b1, `IFMC_OFS_REQ, 8'h00);
        keyPins <= 4'hC;
        repeat (6) @(posedge clk_sys);
        rd(`IFMC_OFS_REQ, 8'h00);
        // watchdog modes: neither software nor the timer sets the watchdog flag
        wdtMode <= 2'h1;
        apb(1'b1, `IFMC_OFS_REQ, 8'h01);
        wdtMode <= 2'h2;
        pulse(8'h01, 1'b0, 1'b0);
        rd(`IFMC_OFS_REQ, 8'h00);
        wdtMode <= 2'h0;
        pulse(8'h01, 1'b0, 1'b0);
        rd(`IFMC_OFS_REQ, 8'h01);
        apb(1'b1, `IFMC_OFS_REQ, 8'h00);
        rd(`IFMC_OFS_REQ, 8'h00);
        // second reset in mid-run, external pin falling and held low through it
        extPin <= 1'b0;
        rstn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(`IFMC_OFS_PSW, 8'h02);
        rd(`IFMC_OFS_MASK, 8'hFF);
        rd(`IFMC_OFS_KEY, 8'h00);
        rd(`IFMC_OFS_EDGE, 8'h00);
        rd(`IFMC_OFS_REQ, 8'h00);
        summarize(0);
    end
endmodule
